// *** include/cirx_pkg.sv ***
// shared constants of the infrared receiver register bank
package cirx_pkg;
    // register offsets within a bank
    localparam logic [2:0] OFF_RX_BUFFER = 3'h0;
    localparam logic [2:0] OFF_IRQ_ENABLE = 3'h1;
    localparam logic [2:0] OFF_IRQ_STATUS = 3'h2;
    localparam logic [2:0] OFF_CONTROL = 3'h3;
    localparam logic [2:0] OFF_LINE_ERROR = 3'h5;
    localparam logic [2:0] OFF_TIMER_LOW = 3'h0;
    localparam logic [2:0] OFF_TIMER_HIGH = 3'h1;
    // bank codes
    localparam logic [1:0] BANK_ZERO = 2'h0;
    localparam logic [1:0] BANK_ONE = 2'h1;
    // field positions
    localparam int BIT_GLOBAL_GATE = 7;
    localparam int BIT_TIMER_FLAG = 2;
    localparam int BIT_LINE_FLAG = 1;
    localparam int BIT_LEVEL_FLAG = 0;
    localparam int BIT_BANK_LO = 6;
    localparam int BIT_TRIG_LO = 4;
    localparam int BIT_READBACK = 3;
    localparam int BIT_TIMER_RUN = 2;
    localparam int BIT_FIFO_CLEAR = 1;
    localparam int BIT_TIMER_CLK = 0;
    localparam int BIT_TIMEOUT = 2;
    localparam int BIT_OVERRUN = 1;
    localparam int BIT_DATA_READY = 0;
    // value after reset and mask of writable irq enable bits
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] ENABLE_MASK = 8'h87;
    // trigger levels in bytes
    localparam logic [4:0] TRIG_LEVEL_0 = 5'h01;
    localparam logic [4:0] TRIG_LEVEL_1 = 5'h04;
    localparam logic [4:0] TRIG_LEVEL_2 = 5'h08;
    localparam logic [4:0] TRIG_LEVEL_3 = 5'h0e;
    // idle time before a receive time-out, in ns, and its cycle count at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int RX_TIMEOUT_NS = 10000;
    localparam int RX_TIMEOUT_CYCLES = RX_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int RX_FIFO_DEPTH = 8;
endpackage

// *** verif/cirx_rx_source.sv ***
// behavioural sampler model that offers received infrared bytes to the register bank
`timescale 1ns/10ps

module cirx_rx_source (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic go,
    input wire logic [7:0] byte_in,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    // offer held until taken; a full fifo leaves it waiting, so the bank sees an overrun
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
        end
        else if (rx_valid && rx_ready)
        begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data; // released data never shows a stale copy
        end
        else if (go && !rx_valid)
        begin
            rx_valid <= 1'b1;
            rx_data <= byte_in;
        end
    end
endmodule

// *** verif/tb_cirx_regs.sv ***
// self-checking bench for the infrared receiver register bank
`timescale 1ns/10ps

module tb_cirx_regs;
    import cirx_pkg::*;
    logic clk;
    logic reset_n;
    logic [2:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic irq;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_ready;
    logic [2:0] errs;
    logic go;
    logic [7:0] byte_in;
    logic rd_d;
    logic [7:0] exp_q[$];
    logic [7:0] bq[$];
    logic [4:0] lv[4];
    int failures;
    int tests_run;
    int cycles;

    cirx_regs #(.DEPTH(8), .TIMEOUT_CYCLES(20)) i_cirx_regs (
        .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .RD(rd), .WR(wr), .WR_DATA(wr_data),
        .RD_DATA(rd_data), .IRQ(irq), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_READY(rx_ready),
        .PARITY_ERR(errs[0]), .STOP_ERR(errs[1]), .SILENT_ERR(errs[2])
    );

    cirx_rx_source i_cirx_rx_source (
        .clk(clk), .reset_n(reset_n), .go(go), .byte_in(byte_in),
        .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data)
    );

    // free running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task close_out;
        // a read whose result never came back counts as a mismatch too
        if (exp_q.size() != 0)
            failures++;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            close_out();
        end
    end

    // read data appears the edge after the strobe is taken; oldest note is compared
    always @(posedge clk)
    begin
        if (rd_d)
        begin
            tests_run++;
            if (exp_q.size() == 0 || rd_data !== exp_q[0])
            begin
                $display("Error RD_DATA expected %h seen %h", exp_q[0], rd_data);
                failures++;
            end
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
        rd_d <= rd;
    end

    task chk(input string name, input logic e, input logic s);
        tests_run++;
        if (s !== e)
        begin
            $display("Error %s expected %b seen %b", name, e, s);
            failures++;
        end
    endtask

    task wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rreg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // hands one byte to the sampler model; hold waits until the fifo takes it
    task send(input logic [7:0] b, input bit hold);
        int n;
        n = 0;
        @(posedge clk);
        go <= 1'b1;
        byte_in <= b;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        while (hold && rx_valid && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
    endtask

    task send_rand;
        logic [7:0] b;
        b = 8'($urandom());
        bq.push_back(b);
        send(b, 1'b1);
    endtask

    task pulse_err(input int i);
        @(posedge clk);
        errs[i] <= 1'b1;
        @(posedge clk);
        errs[i] <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    initial
    begin
        {addr, rd, wr, wr_data, errs, go, byte_in, rd_d} = '0;
        failures = 0;
        tests_run = 0;
        cycles = 0;
        lv = '{TRIG_LEVEL_0, TRIG_LEVEL_1, TRIG_LEVEL_2, TRIG_LEVEL_3};
        void'($urandom(83));
        reset_n = 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        // values after reset, reserved enable bits, read-only buffer
        rreg(OFF_IRQ_ENABLE, RESET_BYTE);
        rreg(OFF_IRQ_STATUS, RESET_BYTE);
        rreg(OFF_CONTROL, RESET_BYTE);
        chk("IRQ", 1'b0, irq);
        wreg(OFF_IRQ_ENABLE, 8'hff);
        rreg(OFF_IRQ_ENABLE, ENABLE_MASK);
        wreg(OFF_RX_BUFFER, 8'h5a);
        rreg(OFF_RX_BUFFER, 8'h00);
        $display("test reset and access done");
        // trigger levels 1, 4 and 8: below, at, and popped back under threshold
        for (int c = 0; c < 3; c++)
        begin
            wreg(OFF_CONTROL, {2'b00, 2'(c), 4'h2});
            repeat (3) @(posedge clk);
            rreg(OFF_CONTROL, {2'b00, 2'(c), 4'h0});
            for (int k = 1; k < lv[c]; k++)
                send_rand();
            rreg(OFF_IRQ_STATUS, 8'h00);
            send_rand();
            rreg(OFF_IRQ_STATUS, 8'h01);
            rreg(OFF_LINE_ERROR, 8'h01);
            chk("IRQ", 1'b1, irq);
            rreg(OFF_RX_BUFFER, bq.pop_front());
            rreg(OFF_IRQ_STATUS, 8'h00);
            while (bq.size() != 0)
                rreg(OFF_RX_BUFFER, bq.pop_front());
            rreg(OFF_LINE_ERROR, 8'h00);
            chk("IRQ", 1'b0, irq);
        end
        $display("test trigger levels done");
        // threshold 14 is out of reach: fill, time out, overrun, clear
        wreg(OFF_CONTROL, 8'h32);
        repeat (3) @(posedge clk);
        for (int k = 0; k < 8; k++)
            send_rand();
        chk("RX_READY", 1'b0, rx_ready);
        repeat (25) @(posedge clk);
        rreg(OFF_IRQ_STATUS, 8'h01);
        send(8'h3c, 1'b0);
        repeat (3) @(posedge clk);
        rreg(OFF_IRQ_STATUS, 8'h03);
        wreg(OFF_CONTROL, 8'h32);
        repeat (4) @(posedge clk);
        rreg(OFF_RX_BUFFER, 8'h3c);
        rreg(OFF_LINE_ERROR, 8'h04);
        rreg(OFF_LINE_ERROR, 8'h00);
        rreg(OFF_IRQ_STATUS, 8'h00);
        bq.delete();
        $display("test full fifo done");
        // each error input pin, with the global gate closed once for each
        for (int i = 0; i < 3; i++)
        begin
            pulse_err(i);
            rreg(OFF_IRQ_STATUS, 8'h02);
            chk("IRQ", 1'b1, irq);
            wreg(OFF_IRQ_ENABLE, 8'h07);
            repeat (2) @(posedge clk);
            chk("IRQ", 1'b0, irq);
            wreg(OFF_IRQ_ENABLE, 8'h87);
            rreg(OFF_LINE_ERROR, 8'h00);
            rreg(OFF_IRQ_STATUS, 8'h00);
        end
        $display("test line errors done");
        // timer reload readback, run, stop, expiry flag
        wreg(OFF_CONTROL, 8'h48);
        wreg(OFF_TIMER_LOW, 8'h05);
        wreg(OFF_TIMER_HIGH, 8'h00);
        rreg(OFF_TIMER_LOW, 8'h05);
        rreg(OFF_TIMER_HIGH, 8'h00);
        rreg(OFF_CONTROL, 8'h48);
        wreg(OFF_CONTROL, 8'h4c);
        repeat (12) @(posedge clk);
        wreg(OFF_CONTROL, 8'h40);
        // stopped on a count of 2; with the test bit off the live count reads back
        rreg(OFF_TIMER_LOW, 8'h02);
        rreg(OFF_TIMER_HIGH, 8'h00);
        wreg(OFF_CONTROL, 8'h00);
        repeat (8) @(posedge clk);
        chk("IRQ", 1'b1, irq);
        rreg(OFF_IRQ_STATUS, 8'h04);
        rreg(OFF_IRQ_STATUS, 8'h00);
        $display("test timer done");
        repeat (3) @(posedge clk);
        close_out();
    end
endmodule

// *** verilog/cirx_regs.sv ***
// infrared receiver register bank with its receive fifo
// Contract
// - sampled infrared bytes enter the receive buffer; host cannot write it.
// - host fetches bytes by programmed reads only; no dma path exists.
// - irq enable, irq status and control registers reset to zero.
// - irq enable bit 7 gates every interrupt onto the output.
// - enable bits: 2 timer, 1 line error, 0 receive level; 6..3 reserved.
// - status bit 2 sets when a running, enabled timer expires at a count of one.
// - status bit 1 sets on line errors; clears when line error register read.
// - status bit 0 sets at level at or over threshold, or time-out below it.
// - status bit 0 clears when buffer reads drop level under threshold.
// - offset 3 holds bank select bits 7:6 in every bank.
// - control bits 5:4 pick threshold of 1, 4, 8 or 14 bytes.
// - control bit 3 makes timer reads return reload values, not live count.
// - control bit 2 runs the timer; clearing it stops it.
// - control bit 1 resets the fifo counters and clears itself.
// - data ready reads 1 while data waits, 0 once empty.
// - time-out bit sets on fifo time-out and clears when read.
`timescale 1ns/10ps

module cirx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic push;
    logic pop;
    logic [LW-1:0] next_level;
    assign push = in_valid && in_ready && !clear;
    assign pop = out_valid && out_ready && !clear;
    assign out_data = mem[rd_ptr];
    // flags held in flops so ready never ripples back combinationally
    always_comb
    begin
        next_level = level;
        if (push && !pop)
            next_level = level + LW'(1);
        else if (pop && !push)
            next_level = level - LW'(1);
    end
    // storage has no reset; only the pointers matter
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
    // pointers wrap; depth is assumed a power of two
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end
        else if (clear)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + AW'(1);
            if (pop)
                rd_ptr <= rd_ptr + AW'(1);
            level <= next_level;
            in_ready <= (next_level != LW'(DEPTH));
            out_valid <= (next_level != '0);
        end
    end
endmodule

module cirx_regs #(
    parameter int DEPTH = cirx_pkg::RX_FIFO_DEPTH,
    parameter int TIMEOUT_CYCLES = cirx_pkg::RX_TIMEOUT_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [2:0] ADDR,
    input wire logic RD,
    input wire logic WR,
    input wire logic [7:0] WR_DATA,
    output logic [7:0] RD_DATA,
    output logic IRQ,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    output logic RX_READY,
    input wire logic PARITY_ERR,
    input wire logic STOP_ERR,
    input wire logic SILENT_ERR
);
    import cirx_pkg::*;
    localparam int LW = $clog2(DEPTH+1);
    logic [7:0] irq_enable;
    logic [2:0] irq_status;
    logic [1:0] bank_choice;
    logic [1:0] rx_fifo_trigger_level;
    logic timer_readback_test;
    logic timer_run;
    logic rx_fifo_clear;
    logic timer_clock_select;
    logic [7:0] timer_reload_low;
    logic [7:0] timer_reload_high;
    logic [15:0] timer_count;
    logic timer_expire;
    logic timer_run_q;
    logic overrun;
    logic rx_timeout_flag;
    logic [31:0] idle_count;
    logic timeout_hit;
    logic fifo_valid;
    logic fifo_ready;
    logic [7:0] fifo_data;
    logic [LW-1:0] level;
    logic [LW-1:0] threshold;
    logic pop;
    logic bank0;
    logic rd_line;
    logic line_event;
    logic [7:0] next_rd_data;
    logic [LW-1:0] next_level;
    assign bank0 = (bank_choice == BANK_ZERO);
    assign pop = RD && bank0 && (ADDR == OFF_RX_BUFFER) && fifo_valid;
    assign rd_line = RD && bank0 && (ADDR == OFF_LINE_ERROR);
    assign RX_READY = fifo_ready;
    // a byte offered while the fifo is full is not taken and counts as overrun
    assign overrun = RX_VALID && !fifo_ready;
    assign line_event = overrun || PARITY_ERR || STOP_ERR || SILENT_ERR;
    // level after this edge, so a pop at the threshold drops the level flag at once
    assign next_level = rx_fifo_clear ? LW'(0) : level + LW'(RX_VALID && fifo_ready) - LW'(pop);
    // receive bytes only enter from the sampler side
    cirx_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .clk(CLK),
        .reset_n(RESET_N),
        .clear(rx_fifo_clear),
        .in_valid(RX_VALID),
        .in_ready(fifo_ready),
        .in_data(RX_DATA),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data),
        .level(level)
    );

    // threshold decode; 14 is out of reach with a shallow fifo
    always_comb
    begin
        case (rx_fifo_trigger_level)
            2'h0: threshold = LW'(TRIG_LEVEL_0);
            2'h1: threshold = LW'(TRIG_LEVEL_1);
            2'h2: threshold = LW'(TRIG_LEVEL_2);
            default: threshold = LW'(TRIG_LEVEL_3);
        endcase
    end

    // irq enable register, reserved bits held at zero
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            irq_enable <= RESET_BYTE;
        else if (WR && bank0 && ADDR == OFF_IRQ_ENABLE)
            irq_enable <= WR_DATA & ENABLE_MASK;
    end

    // control and bank select, the clear bit lasts one cycle
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            bank_choice <= 2'h0;
            rx_fifo_trigger_level <= 2'h0;
            timer_readback_test <= 1'b0;
            timer_run <= 1'b0;
            rx_fifo_clear <= 1'b0;
            timer_clock_select <= 1'b0;
        end
        else
        begin
            rx_fifo_clear <= 1'b0;
            if (WR && ADDR == OFF_CONTROL)
            begin
                bank_choice <= WR_DATA[BIT_BANK_LO+:2];
                rx_fifo_trigger_level <= WR_DATA[BIT_TRIG_LO+:2];
                timer_readback_test <= WR_DATA[BIT_READBACK];
                timer_run <= WR_DATA[BIT_TIMER_RUN];
                rx_fifo_clear <= WR_DATA[BIT_FIFO_CLEAR];
                timer_clock_select <= WR_DATA[BIT_TIMER_CLK];
            end
        end
    end

    // timer reload values live in bank one
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            timer_reload_low <= RESET_BYTE;
            timer_reload_high <= RESET_BYTE;
        end
        else if (WR && bank_choice == BANK_ONE)
        begin
            if (ADDR == OFF_TIMER_LOW)
                timer_reload_low <= WR_DATA;
            if (ADDR == OFF_TIMER_HIGH)
                timer_reload_high <= WR_DATA;
        end
    end

    // down counter reloads on start and on each expiry at a count of one, so one flag per expiry
    assign timer_expire = timer_run && timer_run_q && (timer_count == 16'h0001);
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            timer_count <= 16'h0000;
            timer_run_q <= 1'b0;
        end
        else
        begin
            timer_run_q <= timer_run;
            if (timer_run && (!timer_run_q || timer_expire))
                timer_count <= {timer_reload_high, timer_reload_low};
            else if (timer_run && timer_count != 16'h0000)
                timer_count <= timer_count - 16'h0001;
        end
    end

    // idle counter restarts on every fifo access; held at zero while empty
    assign timeout_hit = fifo_valid && (idle_count == 32'(TIMEOUT_CYCLES - 1));
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            idle_count <= 32'h0000_0000;
        else if (!fifo_valid || pop || (RX_VALID && fifo_ready) || rx_fifo_clear)
            idle_count <= 32'h0000_0000;
        else if (idle_count != 32'(TIMEOUT_CYCLES))
            idle_count <= idle_count + 32'h0000_0001;
    end

    // sticky time-out bit, a new time-out beats the read clear
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            rx_timeout_flag <= 1'b0;
        else if (timeout_hit)
            rx_timeout_flag <= 1'b1;
        else if (rd_line)
            rx_timeout_flag <= 1'b0;
    end

    // status flags; in every case the set wins over the clear
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            irq_status <= 3'h0;
        else
        begin
            if (timer_expire && irq_enable[BIT_TIMER_FLAG])
                irq_status[BIT_TIMER_FLAG] <= 1'b1;
            else if (RD && bank0 && ADDR == OFF_IRQ_STATUS)
                irq_status[BIT_TIMER_FLAG] <= 1'b0;
            if (line_event)
                irq_status[BIT_LINE_FLAG] <= 1'b1;
            else if (rd_line)
                irq_status[BIT_LINE_FLAG] <= 1'b0;
            if (next_level >= threshold || (timeout_hit && level < threshold))
                irq_status[BIT_LEVEL_FLAG] <= 1'b1;
            else if (pop && next_level < threshold)
                irq_status[BIT_LEVEL_FLAG] <= 1'b0;
        end
    end

    // interrupt output, registered so it stays glitch free
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            IRQ <= 1'b0;
        else
            IRQ <= irq_enable[BIT_GLOBAL_GATE] && |(irq_status & irq_enable[2:0]);
    end

    // read mux; unmapped offsets read zero
    always_comb
    begin
        next_rd_data = 8'h00;
        if (ADDR == OFF_CONTROL)
            next_rd_data = {bank_choice, rx_fifo_trigger_level, timer_readback_test, timer_run,
                            1'b0, timer_clock_select};
        else if (bank0)
        begin
            case (ADDR)
                OFF_RX_BUFFER: next_rd_data = fifo_valid ? fifo_data : 8'h00;
                OFF_IRQ_ENABLE: next_rd_data = irq_enable;
                OFF_IRQ_STATUS: next_rd_data = {5'h00, irq_status};
                OFF_LINE_ERROR: next_rd_data = {5'h00, rx_timeout_flag, overrun, fifo_valid};
                default: next_rd_data = 8'h00;
            endcase
        end
        else if (bank_choice == BANK_ONE)
        begin
            case (ADDR)
                OFF_TIMER_LOW: next_rd_data = timer_readback_test ? timer_reload_low : timer_count[7:0];
                OFF_TIMER_HIGH: next_rd_data = timer_readback_test ? timer_reload_high : timer_count[15:8];
                default: next_rd_data = 8'h00;
            endcase
        end
    end

    // read data is captured on the read strobe and held until the next read
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            RD_DATA <= 8'h00;
        else if (RD)
            RD_DATA <= next_rd_data;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    gate_blocks_a: assert property (!irq_enable[BIT_GLOBAL_GATE] |=> !IRQ)
        else $error("irq raised with global gate closed");
    irq_raise_a: assert property (irq_enable[7] && |(irq_status & irq_enable[2:0]) |=> IRQ)
        else $error("enabled flag did not raise irq");
    timer_flag_a: assert property (timer_expire && irq_enable[2] |=> irq_status[2])
        else $error("timer expiry lost");
    line_flag_a: assert property (overrun && !pop && !rx_fifo_clear |=> irq_status[1] && !RX_READY)
        else $error("overrun did not flag line error");
    line_clear_a: assert property (rd_line && !line_event |=> !irq_status[1])
        else $error("line flag survived read");
    level_flag_a: assert property (level >= threshold && !pop |=> irq_status[0])
        else $error("level flag missing");
    data_ready_a: assert property (rd_line |=> RD_DATA[0] == $past(fifo_valid))
        else $error("data ready readback wrong");
    fifo_clear_a: assert property (WR && ADDR == OFF_CONTROL && WR_DATA[1] |=> ##1 level == '0)
        else $error("fifo not cleared");
    bank_write_a: assert property (WR && ADDR == OFF_CONTROL |=> bank_choice == $past(WR_DATA[7:6]))
        else $error("bank select not taken");
    timer_hold_a: assert property (!timer_run |=> timer_count == $past(timer_count))
        else $error("stopped timer moved");
    trig_max_a: assert property (rx_fifo_trigger_level == 2'h3 |-> threshold == LW'(14))
        else $error("top threshold wrong");
    timer_irq_c: cover property (timer_expire ##1 IRQ);
    overrun_c: cover property (overrun);
    timeout_c: cover property (timeout_hit && level < threshold);
endmodule
